/* hw/perf_monitor_pkg.sv */
// Constants, layouts and carriers of the performance monitor counter bank
package perf_monitor_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_LINKS = 4;
  localparam int NUM_CNT   = 9;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_ACCESS_PORT = 10'h00E;
  localparam logic [9:0] IDX_ACCESS_DATA = 10'h00F;
  // Per link copies sit at link * 0x100 plus these
  localparam logic [7:0] IDX_UPDATE_CTRL = 8'hC2;
  localparam logic [7:0] IDX_OVF_EN0     = 8'hC3;
  localparam logic [7:0] IDX_OVF_EN1     = 8'hC4;
  localparam logic [7:0] IDX_OVF_IND0    = 8'hC5;
  localparam logic [7:0] IDX_OVF_IND1    = 8'hC6;
  localparam logic [7:0] IDX_LINE_MODE   = 8'hC7;

  // ==========================================================
  // Field positions and reset values
  localparam int ACC_LINK_LSB    = 4;
  localparam int UPD_MANUAL_BIT  = 0;
  localparam int UPD_AUTO_BIT    = 1;
  localparam int MODE_E1_BIT     = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==========================================================
  // Counter slots; slots 0..7 map to indication 0 bits 0..7
  localparam int C_CRC          = 0;
  localparam int C_FRAMING      = 1;
  localparam int C_ALIGN        = 2;
  localparam int C_FRAME_LOSS   = 3;
  localparam int C_PATTERN      = 4;
  localparam int C_SLOT_A       = 5;
  localparam int C_FAR_BLOCK    = 6;
  localparam int C_NT_FAR_BLOCK = 7;
  localparam int C_LINE_CODE    = 8;
  localparam int CNT_W [NUM_CNT] = '{10, 12, 3, 5, 16, 10, 10, 10, 16};

  // ==========================================================
  // Timebase
  localparam longint ONE_SEC_NS    = 1000000000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int SEC_CYCLES_DEFAULT = int'(ONE_SEC_NS / CLK_PERIOD_NS);

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic line_code;
    logic framing;
    logic crc;
    logic far_block;
    logic align_change;
    logic frame_loss;
    logic pattern;
    logic nt_far_block;
    logic nt_crc;
    logic dds_pattern;
  } link_events_t;

  typedef struct packed {
    logic [1:0] link;
    logic [3:0] id;
  } counter_sel_t;

endpackage

/* hw/perf_monitor_counters.sv */
// Performance monitor counter bank with an AHB-Lite register slave
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ns

module perf_monitor_counters #(
  parameter int SEC_CYCLES = perf_monitor_pkg::SEC_CYCLES_DEFAULT
) (
  input  wire  logic                                hclk,
  input  wire  logic                                hresetn,
  input  wire  logic                                hsel,
  input  wire  logic [31:0]                         haddr,
  input  wire  logic [1:0]                          htrans,
  input  wire  logic                                hwrite,
  input  wire  logic [2:0]                          hsize,
  input  wire  logic [31:0]                         hwdata,
  input  wire  logic                                hready,
  output logic       [31:0]                         hrdata,
  output logic                                      hreadyout,
  output logic                                      hresp,
  input  wire  perf_monitor_pkg::link_events_t [3:0] events,
  output logic                                      perf_irq
);
  import perf_monitor_pkg::*;

  // ==========================================================
  // State
  logic [15:0]  count [NUM_LINKS][NUM_CNT];
  logic         ovf_flag [NUM_LINKS][NUM_CNT];
  logic [7:0]   ovf_en0 [NUM_LINKS];
  logic         ovf_en1 [NUM_LINKS];
  logic [1:0]   upd_ctrl [NUM_LINKS];
  logic         manual_prev [NUM_LINKS];
  logic         e1_mode [NUM_LINKS];
  counter_sel_t sel;
  logic [7:0]   access_data;
  logic [23:0]  sec_cnt;
  logic         sec_tick;
  logic         wr_pend;
  logic         rd_pend;
  logic [9:0]   bus_idx;

  logic [NUM_CNT-1:0] ev [NUM_LINKS];
  logic               manual_rise [NUM_LINKS];
  logic               clr_ind0 [NUM_LINKS];
  logic               clr_ind1 [NUM_LINKS];
  logic               snap;
  logic [7:0]         snap_byte;
  logic [31:0]        rd_value;
  logic               accept;
  logic               any_irq;
  logic               any_en;

  // ==========================================================
  // Event routing
  always_comb
  begin
    for (int l = 0; l < NUM_LINKS; l++)
    begin
      ev[l][C_LINE_CODE]    = events[l].line_code;
      ev[l][C_FRAMING]      = events[l].framing;
      ev[l][C_CRC]          = events[l].crc;
      ev[l][C_FAR_BLOCK]    = events[l].far_block & e1_mode[l];
      ev[l][C_ALIGN]        = events[l].align_change;
      ev[l][C_FRAME_LOSS]   = events[l].frame_loss;
      ev[l][C_PATTERN]      = events[l].pattern;
      ev[l][C_NT_FAR_BLOCK] = events[l].nt_far_block & e1_mode[l];
      ev[l][C_SLOT_A]       = e1_mode[l] ? events[l].nt_crc
                                         : events[l].dds_pattern;
    end
  end

  // ==========================================================
  // Shared one-second timebase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sec_cnt  <= 24'h000000;
      sec_tick <= 1'b0;
    end
    else if (sec_cnt == 24'(SEC_CYCLES - 1))
    begin
      sec_cnt  <= 24'h000000;
      sec_tick <= 1'b1;
    end
    else
    begin
      sec_cnt  <= sec_cnt + 24'h000001;
      sec_tick <= 1'b0;
    end
  end

  // ==========================================================
  // Snapshot trigger and selected byte
  function automatic int id_to_slot(input logic [3:0] id);
    case (id[3:1])
      3'h0:    id_to_slot = C_CRC;
      3'h1:    id_to_slot = C_FRAMING;
      3'h2:    id_to_slot = id[0] ? C_FRAME_LOSS : C_ALIGN;
      3'h3:    id_to_slot = C_PATTERN;
      3'h4:    id_to_slot = C_LINE_CODE;
      3'h5:    id_to_slot = C_SLOT_A;
      3'h6:    id_to_slot = C_FAR_BLOCK;
      default: id_to_slot = C_NT_FAR_BLOCK;
    endcase
  endfunction

  always_comb
  begin
    for (int l = 0; l < NUM_LINKS; l++)
      manual_rise[l] = upd_ctrl[l][UPD_MANUAL_BIT] & ~manual_prev[l];
  end

  assign snap = manual_rise[sel.link]
              | (upd_ctrl[sel.link][UPD_AUTO_BIT] & sec_tick);

  always_comb
  begin
    logic [15:0] value;
    value = count[sel.link][id_to_slot(sel.id)];
    if (sel.id[0] && sel.id[3:1] != 3'h2)
      snap_byte = value[15:8];
    else
      snap_byte = value[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      access_data <= RST_BYTE;
    else if (snap)
      access_data <= snap_byte;
  end

  // ==========================================================
  // Counters and overflow flags
  for (genvar l = 0; l < NUM_LINKS; l++)
  begin : g_link
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        manual_prev[l] <= 1'b0;
      else
        manual_prev[l] <= upd_ctrl[l][UPD_MANUAL_BIT];
    end

    for (genvar k = 0; k < NUM_CNT; k++)
    begin : g_cnt
      localparam logic [15:0] MAXV = 16'((32'd1 << CNT_W[k]) - 1);
      logic clearing;
      logic read_clear;
      assign clearing   = snap && (sel.link == 2'(l));
      assign read_clear = (k == C_LINE_CODE) ? clr_ind1[l] : clr_ind0[l];

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          count[l][k] <= 16'h0000;
        else if (clearing)
          count[l][k] <= {15'h0000, ev[l][k]};
        else if (ev[l][k])
          count[l][k] <= (count[l][k] + 16'h0001) & MAXV;
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          ovf_flag[l][k] <= 1'b0;
        else if (!clearing && ev[l][k] && count[l][k] == MAXV)
          ovf_flag[l][k] <= 1'b1;
        else if (read_clear)
          ovf_flag[l][k] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt output
  always_comb
  begin
    any_irq = 1'b0;
    any_en  = 1'b0;
    for (int l = 0; l < NUM_LINKS; l++)
    begin
      any_en = any_en | (|ovf_en0[l]) | ovf_en1[l];
      any_irq = any_irq | (ovf_flag[l][C_LINE_CODE] & ovf_en1[l]);
      for (int k = 0; k < C_LINE_CODE; k++)
        any_irq = any_irq | (ovf_flag[l][k] & ovf_en0[l][k]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      perf_irq <= 1'b0;
    else
      perf_irq <= any_irq;
  end

  // ==========================================================
  // AHB-Lite slave
  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      bus_idx   <= 10'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend   <= accept && hwrite;
      rd_pend   <= accept && !hwrite;
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
      if (accept)
        bus_idx <= haddr[11:2];
    end
  end

  always_comb
  begin
    rd_value = 32'h00000000;
    for (int l = 0; l < NUM_LINKS; l++)
    begin
      clr_ind0[l] = 1'b0;
      clr_ind1[l] = 1'b0;
    end
    if (bus_idx == IDX_ACCESS_PORT)
      rd_value[5:0] = sel;
    else if (bus_idx == IDX_ACCESS_DATA)
      rd_value[7:0] = access_data;
    else
    begin
      case (bus_idx[7:0])
        IDX_UPDATE_CTRL: rd_value[1:0] = upd_ctrl[bus_idx[9:8]];
        IDX_OVF_EN0:     rd_value[7:0] = ovf_en0[bus_idx[9:8]];
        IDX_OVF_EN1:     rd_value[0]   = ovf_en1[bus_idx[9:8]];
        IDX_LINE_MODE:   rd_value[0]   = e1_mode[bus_idx[9:8]];
        IDX_OVF_IND0:
        begin
          for (int k = 0; k < C_LINE_CODE; k++)
            rd_value[k] = ovf_flag[bus_idx[9:8]][k];
          clr_ind0[bus_idx[9:8]] = rd_pend;
        end
        IDX_OVF_IND1:
        begin
          rd_value[0] = ovf_flag[bus_idx[9:8]][C_LINE_CODE];
          clr_ind1[bus_idx[9:8]] = rd_pend;
        end
        default: rd_value = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_pend)
      hrdata <= rd_value;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel <= '0;
    else if (wr_pend && bus_idx == IDX_ACCESS_PORT)
      sel <= hwdata[5:0];
  end

  for (genvar l = 0; l < NUM_LINKS; l++)
  begin : g_regs
    logic hit;
    assign hit = wr_pend && bus_idx[9:8] == 2'(l);
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        upd_ctrl[l] <= 2'h0;
        ovf_en0[l]  <= RST_BYTE;
        ovf_en1[l]  <= 1'b0;
        e1_mode[l]  <= 1'b0;
      end
      else if (hit)
      begin
        if (bus_idx[7:0] == IDX_UPDATE_CTRL)
          upd_ctrl[l] <= hwdata[1:0];
        if (bus_idx[7:0] == IDX_OVF_EN0)
          ovf_en0[l] <= hwdata[7:0];
        if (bus_idx[7:0] == IDX_OVF_EN1)
          ovf_en1[l] <= hwdata[0];
        if (bus_idx[7:0] == IDX_LINE_MODE)
          e1_mode[l] <= hwdata[MODE_E1_BIT];
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_manual_copy: assert property (
    manual_rise[sel.link] |=> access_data == $past(snap_byte))
    else $error("manual update did not copy counter");

  a_auto_report: assert property (
    (upd_ctrl[sel.link][UPD_AUTO_BIT] && sec_tick) |=> access_data == $past(snap_byte)
      && count[$past(sel.link)][C_FRAME_LOSS] == 16'($past(ev[sel.link][C_FRAME_LOSS])))
    else $error("auto report did not snapshot");

  a_group_clear: assert property (
    snap |=> count[$past(sel.link)][C_LINE_CODE] <= 16'h0001
          && count[$past(sel.link)][C_CRC] <= 16'h0001)
    else $error("link counters not cleared");

  a_event_kept: assert property (
    (snap && ev[sel.link][C_FRAME_LOSS]) |=> count[$past(sel.link)][C_FRAME_LOSS] == 16'h0001)
    else $error("event lost at snapshot");

  a_ovf_set: assert property (
    (count[1][C_ALIGN] == 16'h0007 && ev[1][C_ALIGN] && !(snap && sel.link == 2'h1))
      |=> ovf_flag[1][C_ALIGN] && count[1][C_ALIGN] == 16'h0000)
    else $error("overflow not flagged");

  a_irq_gated: assert property (
    !any_en |=> !perf_irq)
    else $error("interrupt without enable");

  a_irq_line: assert property (
    (ovf_flag[1][C_LINE_CODE] && ovf_en1[1]) |=> perf_irq)
    else $error("line code overflow not reported");

  a_tick_spacing: assert property (
    sec_tick |-> sec_cnt == 24'h000000 ##1 !sec_tick)
    else $error("timebase tick malformed");

  a_t1_far_quiet: assert property (
    (!e1_mode[0] && !(snap && sel.link == 2'h0))
      |=> count[0][C_FAR_BLOCK] == $past(count[0][C_FAR_BLOCK]))
    else $error("far block counted outside E1");

  a_read_wait: assert property (
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

endmodule

/* tb/event_source.sv */
// Framer side model: bursts of one-cycle event pulses on one link
`timescale 1ns/1ns

module event_source (
  input  wire  logic                                hclk,
  input  wire  logic                                hresetn,
  input  wire  logic                                go,
  input  wire  logic [1:0]                          link,
  input  wire  perf_monitor_pkg::link_events_t      mask,
  input  wire  logic [15:0]                         count,
  output perf_monitor_pkg::link_events_t [3:0]      events,
  output logic                                      busy
);
  import perf_monitor_pkg::*;

  logic [15:0] remain;

  assign busy = (remain != 16'h0000);

  // One pulse per cycle, lines low between bursts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      remain <= 16'h0000;
      events <= '0;
    end
    else
    begin
      events <= '0;
      if (remain != 16'h0000)
      begin
        events[link] <= mask;
        remain       <= remain - 16'h0001;
      end
      else if (go)
        remain <= count;
    end
  end
endmodule

/* tb/perf_monitor_counters_tb.sv */
// Self-checking bench of the performance monitor counter bank
`timescale 1ns/1ns

module perf_monitor_counters_tb;
  import perf_monitor_pkg::*;

  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, perf_irq, go, busy;
  logic [31:0]        haddr, hwdata, hrdata, d, d1;
  logic [1:0]         htrans, ev_link;
  logic [2:0]         hsize;
  logic [15:0]        ev_count;
  link_events_t       ev_mask;
  link_events_t [3:0] events;
  int                 n_mismatch, tests_run, i;

  perf_monitor_counters #(.SEC_CYCLES(20)) perf_monitor_counters_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .events(events), .perf_irq(perf_irq));

  event_source event_source_inst (
    .hclk(hclk), .hresetn(hresetn), .go(go), .link(ev_link), .mask(ev_mask),
    .count(ev_count), .events(events), .busy(busy));

  // ==========================================================
  // Helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {20'h00000, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, idx, wd, x);
  endtask

  task automatic rdchk(input string name, input logic [9:0] idx, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, idx, 32'h00000000, x);
    chk(name, e, x);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  function automatic link_events_t mk(input int b);
    link_events_t m;
    m    = '0;
    m[b] = 1'b1;
    return m;
  endfunction

  task automatic snap(input logic [1:0] l, input logic [3:0] id, output logic [31:0] q);
    wr(IDX_ACCESS_PORT, {26'h0000000, l, 4'h0});
    wr(IDX_ACCESS_PORT, {26'h0000000, l, id});
    wr({l, IDX_UPDATE_CTRL}, 32'h00000000);
    wr({l, IDX_UPDATE_CTRL}, 32'h00000001);
    bus(1'b0, IDX_ACCESS_DATA, 32'h00000000, q);
  endtask

  task automatic burst(input logic [1:0] l, input int b, input int n, input logic wt);
    @(posedge hclk);
    ev_link  <= l;
    ev_mask  <= mk(b);
    ev_count <= 16'(n);
    go       <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    if (wt)
      do @(posedge hclk); while (busy);
  endtask

  task automatic one_count(input string nm, input logic [1:0] l, input int b, input logic [3:0] id,
                           input int n, input logic [31:0] e);
    logic [31:0] q;
    snap(l, id, q);
    burst(l, b, n, 1'b1);
    snap(l, id, q);
    chk(nm, e, q);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdchk("ctrl", {2'd0, IDX_UPDATE_CTRL}, 32'h00000000);
    rdchk("en0", {2'd1, IDX_OVF_EN0}, 32'h00000000);
    rdchk("ind1", {2'd3, IDX_OVF_IND1}, 32'h00000000);
    rdchk("port", IDX_ACCESS_PORT, 32'h00000000);
    rdchk("unmapped", 10'h3FF, 32'h00000000);
    wr({2'd2, IDX_OVF_EN1}, 32'h00000001);
    rdchk("en1", {2'd2, IDX_OVF_EN1}, 32'h00000001);
    wr({2'd2, IDX_OVF_EN0}, 32'h000000A5);
    rdchk("en0", {2'd2, IDX_OVF_EN0}, 32'h000000A5);
    wr({2'd2, IDX_OVF_EN0}, 32'h00000000);
    $display("registers done");
  endtask

  task automatic t_counters;
    one_count("crc", 2'd0, 7, 4'h0, 9, 32'h09);
    one_count("framing lo", 2'd0, 8, 4'h2, 261, 32'h05);
    one_count("framing hi", 2'd0, 8, 4'h3, 261, 32'h01);
    one_count("pattern hi", 2'd3, 3, 4'h7, 515, 32'h02);
    one_count("line lo", 2'd2, 9, 4'h8, 300, 32'h2C);
    one_count("line hi", 2'd2, 9, 4'h9, 300, 32'h01);
    one_count("frame loss", 2'd1, 4, 4'h5, 31, 32'h1F);
    one_count("align", 2'd1, 5, 4'h4, 5, 32'h05);
    wr({2'd0, IDX_LINE_MODE}, 32'h00000001);
    one_count("far block", 2'd0, 6, 4'hC, 4, 32'h04);
    one_count("nt far block", 2'd0, 2, 4'hE, 6, 32'h06);
    one_count("nt crc", 2'd0, 1, 4'hA, 3, 32'h03);
    wr({2'd0, IDX_LINE_MODE}, 32'h00000000);
    one_count("dds", 2'd0, 0, 4'hA, 7, 32'h07);
    one_count("far block t1", 2'd0, 6, 4'hC, 4, 32'h00);
    $display("counters done");
  endtask

  task automatic t_overflow;
    snap(2'd1, 4'h4, d);
    bus(1'b0, {2'd1, IDX_OVF_IND0}, 32'h00000000, d);
    burst(2'd1, 5, 8, 1'b1);
    repeat (3) @(posedge hclk);
    chk("irq masked", 32'h0, {31'h0, perf_irq});
    wr({2'd1, IDX_OVF_EN0}, 32'h00000004);
    repeat (3) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, perf_irq});
    rdchk("ind0", {2'd1, IDX_OVF_IND0}, 32'h00000004);
    rdchk("ind0 cleared", {2'd1, IDX_OVF_IND0}, 32'h00000000);
    repeat (3) @(posedge hclk);
    chk("irq off", 32'h0, {31'h0, perf_irq});
    snap(2'd1, 4'h4, d);
    chk("wrapped", 32'h0, d);
    wr({2'd1, IDX_OVF_EN1}, 32'h00000001);
    burst(2'd1, 9, 65535, 1'b1);
    burst(2'd1, 9, 1, 1'b1);
    repeat (3) @(posedge hclk);
    chk("line irq", 32'h1, {31'h0, perf_irq});
    rdchk("ind1 line", {2'd1, IDX_OVF_IND1}, 32'h00000001);
    wr({2'd1, IDX_OVF_EN1}, 32'h00000000);
    wr({2'd1, IDX_OVF_EN0}, 32'h00000000);
    $display("overflow done");
  endtask

  task automatic t_no_loss;
    snap(2'd3, 4'h5, d);
    burst(2'd3, 4, 20, 1'b0);
    snap(2'd3, 4'h5, d1);
    while (busy) @(posedge hclk);
    snap(2'd3, 4'h5, d);
    chk("split sum", 32'd20, d1 + d);
    $display("no loss done");
  endtask

  task automatic t_auto;
    snap(2'd3, 4'h5, d);
    burst(2'd3, 4, 1, 1'b1);
    wr({2'd3, IDX_UPDATE_CTRL}, 32'h00000002);
    for (i = 0; i < 20 && d !== 32'h1; i++)
      bus(1'b0, IDX_ACCESS_DATA, 32'h00000000, d);
    chk("auto", 32'h1, d);
    repeat (45) @(posedge hclk);
    rdchk("auto next", IDX_ACCESS_DATA, 32'h00000000);
    wr({2'd3, IDX_UPDATE_CTRL}, 32'h00000000);
    $display("auto done");
  endtask

  task automatic final_report;
    $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Clock, reset, sequence
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial
  begin
    #(100 * 90000);
    n_mismatch++;
    final_report;
  end

  initial
  begin
    n_mismatch = 0;
    tests_run  = 0;
    hresetn    = 1'b0;
    hsel       = 1'b0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'b010;
    haddr      = 32'h00000000;
    hwdata     = 32'h00000000;
    go         = 1'b0;
    ev_link    = 2'd0;
    ev_mask    = '0;
    ev_count   = 16'h0000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_counters;
    t_overflow;
    t_no_loss;
    t_auto;
    final_report;
  end
endmodule
